// ---- dpumm_access_check.sv ----
// Per-access permission decision for one port of the memory map.
// Assumes the requester presents the sector's protection state steadily.
`timescale 1ns/1ps
`default_nettype none

module dpumm_access_check (
  // Request and verdict
  dpumm_chk_if.decider chk
);

  logic [1:0] prot;

  always_comb
  begin
    prot = chk.access_byte[dpumm_pkg::SAB_PROT_LO +: 2];
    chk.rd_ok = 1'b1;
    chk.wr_ok = 1'b1;
    if (chk.serial_mode)
    begin
      chk.wr_ok = ~chk.wr_lock;
    end
    else if (chk.access_byte[dpumm_pkg::SAB_LOCK_BIT])
    begin
      case (prot)
        dpumm_pkg::PROT_RD_FREE:
        begin
          chk.rd_ok = 1'b1;
          chk.wr_ok = chk.pwd_ok;
        end
        dpumm_pkg::PROT_ALL_FREE:
        begin
          chk.rd_ok = 1'b1;
          chk.wr_ok = 1'b1;
        end
        dpumm_pkg::PROT_ALL_PWD:
        begin
          chk.rd_ok = chk.pwd_ok;
          chk.wr_ok = chk.pwd_ok;
        end
        // Undefined code: fail safe, treat as fully password guarded
        default:
        begin
          chk.rd_ok = chk.pwd_ok;
          chk.wr_ok = chk.pwd_ok;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- dpumm_chk_if.sv ----
// Carrier between the memory map top and its access check module.
// Assumes both ends run on the same clock; contents are combinational.
`timescale 1ns/1ps
`default_nettype none

interface dpumm_chk_if;
  logic [7:0] access_byte;
  logic       pwd_ok;
  logic       wr_lock;
  logic       serial_mode;
  logic       rd_ok;
  logic       wr_ok;

  modport requester (output access_byte, output pwd_ok, output wr_lock,
                     output serial_mode, input rd_ok, input wr_ok);
  modport decider   (input access_byte, input pwd_ok, input wr_lock,
                     input serial_mode, output rd_ok, output wr_ok);
endinterface

`default_nettype wire

// ---- dpumm_pkg.sv ----
// Constants for the dual-interface user memory map: array geometry,
// sector access byte layout, serial select code fields, reset values.
// Assumes nothing of its surroundings; used as dpumm_pkg::name only.
package dpumm_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int SECTORS           = 64;
  localparam int BLOCKS_PER_SECTOR = 32;
  localparam int BLOCK_W           = 32;
  localparam int BYTE_W            = 8;
  localparam int BYTES_PER_BLOCK   = BLOCK_W / BYTE_W;
  localparam int BYTES_PER_SECTOR  = BLOCKS_PER_SECTOR * BYTES_PER_BLOCK;
  localparam int SECTOR_BITS       = BLOCKS_PER_SECTOR * BLOCK_W;
  localparam int PWD_BLOCKS        = 4;
  localparam int PWD_SERIAL_IDX    = 0;
  localparam int UID_W             = 64;
  localparam int ID_W              = 8;

  // ----------------------------------------------------------------
  // Sector access byte
  // ----------------------------------------------------------------
  localparam logic [7:0] SAB_RESET    = 8'h00;
  localparam int         SAB_LOCK_BIT = 0;
  localparam int         SAB_PROT_LO  = 1;
  localparam logic [1:0] PROT_RD_FREE = 2'h0;
  localparam logic [1:0] PROT_ALL_FREE = 2'h1;
  localparam logic [1:0] PROT_ALL_PWD = 2'h2;

  // ----------------------------------------------------------------
  // Serial device select code
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int         DSEL_TYPE_LO  = 4;
  localparam int         DSEL_AREA_BIT = 3;
  localparam int         DSEL_CS_HI    = 2;
  localparam int         DSEL_CS_LO    = 1;
  localparam int         DSEL_RW_BIT   = 0;
  localparam logic       AREA_USER     = 1'b0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ID_RESET  = 8'h00;
  localparam logic [31:0] PWD_RESET = 32'h0000_0000;

endpackage

// ---- dpumm_ser_master.sv ----
// Serial engine stand-in: one byte access per serial clock rise.
// Assumes a 13-bit byte address; replies are caught on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module dpumm_ser_master (
  // Clock and replies
  input  wire logic        ref_clk,
  input  wire logic        ser_ack,
  input  wire logic        ser_denied,
  input  wire logic [7:0]  ser_rdata,
  // Request towards the memory map
  output logic             ser_scl,
  output logic             ser_req,
  output logic [7:0]       ser_dev_sel,
  output logic [12:0]      ser_addr,
  output logic [7:0]       ser_wdata
);
  logic       got = 1'b0;
  logic       den = 1'b0;
  logic [7:0] rd  = 8'h00;

  initial
  begin
    ser_scl = 1'b0;
    ser_req = 1'b0;
    ser_dev_sel = 8'h00;
    ser_addr = 13'h0000;
    ser_wdata = 8'h00;
  end

  always @(posedge ref_clk)
    if (ser_ack)
    begin
      got <= 1'b1;
      den <= ser_denied;
      rd <= ser_rdata;
    end

  // Clock stands low outside the access; 80 ns period inside it
  task automatic xfer(input logic [7:0] sel, input logic [12:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    got = 1'b0;
    ser_req = 1'b1;
    ser_dev_sel = sel;
    ser_addr = a;
    ser_wdata = d;
    repeat (5) @(negedge ref_clk);
    ser_scl = 1'b1;
    repeat (5) @(negedge ref_clk);
    ser_scl = 1'b0;
    repeat (5) @(negedge ref_clk);
    // Released fields show junk, not the last value
    ser_req = 1'b0;
    ser_dev_sel = ~sel;
    ser_addr = ~a;
    ser_wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ---- dpumm_tb_top.sv ----
// Testbench for the user memory map: protection table on the block
// port, byte port mapping and locks, system area. Drives at falling edge.
`timescale 1ns/1ps
`default_nettype none

module dpumm_tb_top;
  typedef struct packed {logic [7:0] sab; logic we; logic pwd; logic den;} dpumm_row_t;
  localparam logic [63:0] UID_EXP = 64'h0123_4567_89ab_cdef; // Arbitrary value
  localparam dpumm_row_t ROWS [10] = '{
    '{8'h00, 1'b1, 1'b0, 1'b0}, '{8'h01, 1'b1, 1'b0, 1'b1}, '{8'h01, 1'b1, 1'b1, 1'b0},
    '{8'h01, 1'b0, 1'b0, 1'b0}, '{8'h03, 1'b1, 1'b0, 1'b0}, '{8'h03, 1'b0, 1'b0, 1'b0},
    '{8'h05, 1'b0, 1'b0, 1'b1}, '{8'h05, 1'b1, 1'b0, 1'b1}, '{8'h05, 1'b0, 1'b1, 1'b0},
    '{8'h07, 1'b1, 1'b0, 1'b1}};
  logic ref_clk = 1'b0, rst_n = 1'b0, rf_req = 1'b0, rf_we = 1'b0, rf_pwd_ok = 1'b0;
  logic [10:0] rf_block = 11'h000;
  logic [31:0] rf_wdata = 32'h0000_0000, pwd_data = 32'h0000_0000, pwd_cand = 32'h0000_0000;
  logic [63:0] ser_wr_lock = 64'h0;
  logic sab_wr = 1'b0, id_wr = 1'b0, id_sel_dsfid = 1'b0, pwd_wr = 1'b0, ce = 1'b1;
  logic [5:0] sab_sector = 6'h00;
  logic [7:0] sab_data = 8'h00, id_data = 8'h00;
  logic [1:0] pwd_idx = 2'h0;
  logic rf_ack, rf_denied, ser_ack, ser_denied;
  logic [31:0] rf_rdata, model;
  logic [7:0] ser_rdata, afi, dsfid;
  logic [63:0] uid;
  logic [3:0] pwd_match;
  logic [63:0][7:0] sector_access_byte;
  wire logic ser_scl, ser_req;
  wire logic [7:0] ser_dev_sel, ser_wdata;
  wire logic [12:0] ser_addr;
  int num_errors = 0, checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  dpumm_top #(.UID_VALUE(UID_EXP)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .rf_req(rf_req), .rf_we(rf_we), .rf_block(rf_block), .rf_wdata(rf_wdata),
    .rf_pwd_ok(rf_pwd_ok), .rf_ack(rf_ack), .rf_denied(rf_denied), .rf_rdata(rf_rdata),
    .ser_scl(ser_scl), .ser_req(ser_req), .ser_dev_sel(ser_dev_sel), .ser_addr(ser_addr),
    .ser_wdata(ser_wdata), .chip_select_bit_high(1'b1), .chip_select_bit_low(1'b0),
    .ser_wr_lock(ser_wr_lock), .ser_ack(ser_ack), .ser_denied(ser_denied),
    .ser_rdata(ser_rdata), .sab_wr(sab_wr), .sab_sector(sab_sector), .sab_data(sab_data),
    .id_wr(id_wr), .id_sel_dsfid(id_sel_dsfid), .id_data(id_data), .pwd_wr(pwd_wr),
    .pwd_idx(pwd_idx), .pwd_data(pwd_data), .pwd_cand(pwd_cand), .afi(afi), .dsfid(dsfid),
    .uid(uid), .pwd_match(pwd_match), .sector_access_byte(sector_access_byte));

  dpumm_ser_master mst (.ref_clk(ref_clk), .ser_ack(ser_ack), .ser_denied(ser_denied),
    .ser_rdata(ser_rdata), .ser_scl(ser_scl), .ser_req(ser_req), .ser_dev_sel(ser_dev_sel),
    .ser_addr(ser_addr), .ser_wdata(ser_wdata));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rf_op(input logic we, input logic [10:0] blk, input logic [31:0] d,
                       input logic pw);
    @(negedge ref_clk);
    rf_req = 1'b1;
    rf_we = we;
    rf_block = blk;
    rf_wdata = d;
    rf_pwd_ok = pw;
    @(negedge ref_clk);
    check(rf_ack, 1'b1, "block ack");
    rf_req = 1'b0;
  endtask

  task automatic sab_set(input logic [5:0] s, input logic [7:0] v);
    @(negedge ref_clk);
    sab_wr = 1'b1;
    sab_sector = s;
    sab_data = v;
    @(negedge ref_clk);
    sab_wr = 1'b0;
    @(negedge ref_clk);
    check(sector_access_byte[s], v, "access byte");
  endtask

  initial
  begin
    #50_000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    logic [7:0] bad [3];
    bad = '{8'hac, 8'ha0, 8'h24};
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(|sector_access_byte, 1'b0, "access bytes after reset");
    check(uid, UID_EXP, "identifier");
    // Reset passwords equal the idle candidate of zero, so all four match
    check({afi, dsfid, pwd_match}, 20'h0_000f, "system area after reset");
    $display("test reset done");
    // ------------------------------------------------------------
    // Protection table on one sector
    // ------------------------------------------------------------
    for (int i = 0; i < 10; i++)
    begin
      sab_set(6'h01, ROWS[i].sab);
      rf_op(ROWS[i].we, 11'h020, 32'(32'h1111_1111 * (i + 1)), ROWS[i].pwd);
      check(rf_denied, ROWS[i].den, "block verdict");
      if (ROWS[i].we && !ROWS[i].den)
        model = 32'(32'h1111_1111 * (i + 1));
      else if (!ROWS[i].we)
        check(rf_rdata, ROWS[i].den ? 32'h0 : model, "block data");
    end
    $display("test protection done");
    // ------------------------------------------------------------
    // Byte port on the last block
    // ------------------------------------------------------------
    rf_op(1'b1, 11'h7ff, 32'hcafe_f00d, 1'b0);
    mst.xfer(8'ha4, 13'h1fff, 8'h5a);
    check({mst.got, mst.den}, 2'b10, "byte write");
    rf_op(1'b0, 11'h7ff, 32'h0, 1'b0);
    check(rf_rdata, 32'h5afe_f00d, "lane mapping");
    ser_wr_lock[63] = 1'b1;
    mst.xfer(8'ha4, 13'h1ffc, 8'h33);
    check({mst.got, mst.den}, 2'b11, "locked byte write");
    ser_wr_lock[63] = 1'b0;
    mst.xfer(8'ha5, 13'h1ffd, 8'h00);
    check({mst.got, mst.den, mst.rd}, 10'h2f0, "byte read");
    foreach (bad[i])
    begin
      mst.xfer(bad[i], 13'h1ffc, 8'h77);
      check(mst.got, 1'b0, "bad select answered");
    end
    rf_op(1'b0, 11'h7ff, 32'h0, 1'b0);
    check(rf_rdata, 32'h5afe_f00d, "refused bytes changed memory");
    $display("test byte port done");
    // ------------------------------------------------------------
    // Identifiers and passwords
    // ------------------------------------------------------------
    for (int i = 0; i < 2; i++)
    begin
      @(negedge ref_clk);
      id_wr = 1'b1;
      id_sel_dsfid = 1'(i);
      id_data = 8'(8'h3c + i);
    end
    @(negedge ref_clk);
    id_wr = 1'b0;
    pwd_cand = 32'h1234_5678;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      pwd_wr = 1'b1;
      pwd_idx = 2'(i);
      pwd_data = (i == 2) ? 32'h0 : pwd_cand;
    end
    @(negedge ref_clk);
    pwd_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({afi, dsfid}, 16'h3c3d, "identifier registers");
    check(pwd_match, 4'hb, "password match");
    $display("test system area done");
    // ------------------------------------------------------------
    // Reset in mid-run and a frozen cycle
    // ------------------------------------------------------------
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(|sector_access_byte, 1'b0, "access bytes after second reset");
    check({afi, dsfid}, 16'h0000, "identifiers after second reset");
    // Enable low: the id write pulse must be ignored
    ce = 1'b0;
    id_wr = 1'b1;
    id_data = 8'h99;
    @(negedge ref_clk);
    id_wr = 1'b0;
    ce = 1'b1;
    @(negedge ref_clk);
    check({afi, dsfid}, 16'h0000, "write taken while frozen");
    // Array is nonvolatile: the block written before reset reads back
    rf_op(1'b0, 11'h020, 32'h0, 1'b0);
    check(rf_rdata, model, "array lost over reset");
    $display("test second reset done");
    print_verdict();
  end
endmodule

`default_nettype wire

// ---- dpumm_top.sv ----
// User memory map with contactless block port and serial byte port.
// Assumes protocol engines outside: RF engine on ref_clk, serial engine
// holds its request steady across the serial clock's high phase.
//
// Overview of operation
// - Array is 64 sectors of 32 blocks, 32 bits each, 1024 bits per sector.
// - Each sector protectable; accesses proceed only when the sector allows them.
// - 64-bit identifier fixed at build, never reachable through user accesses.
// - Separate 8-bit family and storage format identifier registers held.
// - Four 32-bit password blocks: one serial, three contactless.
// - Contactless side reads and writes whole blocks; writes replace all 32 bits.
// - Contactless permission comes from the sector's single access byte.
// - Serial side sees each sector as 128 individually accessible bytes.
// - Serial writes refused for every byte of a write-locked sector.
// - Area bit is select bit 3, taken only from the received select byte.
// - All sector access bytes reset to 00h, leaving every sector unlocked.
// - Locked sector: 00 read free, 01 all free, 10 all need password.
`timescale 1ns/1ps
`default_nettype none

module dpumm_top #(
  parameter int          SECTORS           = dpumm_pkg::SECTORS,
  parameter int          BLOCKS_PER_SECTOR = dpumm_pkg::BLOCKS_PER_SECTOR,
  // Arbitrary value, stands in for the factory identifier
  parameter logic [63:0] UID_VALUE         = 64'h0123_4567_89ab_cdef,
  localparam int         WORDS             = SECTORS * BLOCKS_PER_SECTOR,
  localparam int         BLK_AW            = $clog2(WORDS),
  localparam int         SEC_AW            = $clog2(SECTORS),
  localparam int         ADDR_W            = BLK_AW + 2
) (
  // Clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Contactless block port
  input  wire logic                 rf_req,
  input  wire logic                 rf_we,
  input  wire logic [BLK_AW-1:0]    rf_block,
  input  wire logic [31:0]          rf_wdata,
  input  wire logic                 rf_pwd_ok,
  output logic                      rf_ack,
  output logic                      rf_denied,
  output logic [31:0]               rf_rdata,
  // Serial byte port and chip select pins
  input  wire logic                 ser_scl,
  input  wire logic                 ser_req,
  input  wire logic [7:0]           ser_dev_sel,
  input  wire logic [ADDR_W-1:0]    ser_addr,
  input  wire logic [7:0]           ser_wdata,
  input  wire logic                 chip_select_bit_high,
  input  wire logic                 chip_select_bit_low,
  input  wire logic [SECTORS-1:0]   ser_wr_lock,
  output logic                      ser_ack,
  output logic                      ser_denied,
  output logic [7:0]                ser_rdata,
  // System area
  input  wire logic                 sab_wr,
  input  wire logic [SEC_AW-1:0]    sab_sector,
  input  wire logic [7:0]           sab_data,
  input  wire logic                 id_wr,
  input  wire logic                 id_sel_dsfid,
  input  wire logic [7:0]           id_data,
  input  wire logic                 pwd_wr,
  input  wire logic [1:0]           pwd_idx,
  input  wire logic [31:0]          pwd_data,
  input  wire logic [31:0]          pwd_cand,
  output logic [7:0]                afi,
  output logic [7:0]                dsfid,
  output logic [63:0]               uid,
  output logic [3:0]                pwd_match,
  output logic [SECTORS-1:0][7:0]   sector_access_byte
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int SV_W = 1 + 8 + ADDR_W + 8 + 2;

  typedef struct packed {
    logic [WORDS-1:0][31:0]   mem;
    logic [SECTORS-1:0][7:0]  sab;
    logic [7:0]               afi;
    logic [7:0]               dsfid;
    logic [3:0][31:0]         pwd;
    logic [3:0]               pwd_match;
    logic [63:0]              uid;
    logic                     scl_s1;
    logic                     scl_s2;
    logic                     scl_prev;
    logic [SV_W-1:0]          in_s1;
    logic [SV_W-1:0]          in_s2;
    logic                     rf_ack;
    logic                     rf_denied;
    logic [31:0]              rf_rdata;
    logic                     ser_ack;
    logic                     ser_denied;
    logic [7:0]               ser_rdata;
  } dpumm_state_t;

  dpumm_state_t r_reg;
  dpumm_state_t r_next;

  // ----------------------------------------------------------------
  // Synchronised serial request fields, plus the block port's sector
  // ----------------------------------------------------------------
  logic              s_req;
  logic [7:0]        s_dsel;
  logic [ADDR_W-1:0] s_addr;
  logic [7:0]        s_wdata;
  logic              s_cs_hi;
  logic              s_cs_lo;
  logic              scl_rise;
  logic              s_select;
  logic [BLK_AW-1:0] s_word;
  logic [1:0]        s_lane;
  logic [SEC_AW-1:0] s_sector;
  logic [SEC_AW-1:0] rf_sector;

  assign {s_req, s_dsel, s_addr, s_wdata, s_cs_hi, s_cs_lo} = r_reg.in_s2;
  assign scl_rise  = r_reg.scl_s2 & ~r_reg.scl_prev;
  assign s_word    = s_addr[ADDR_W-1:2];
  assign s_lane    = s_addr[1:0];
  assign s_sector  = s_addr[ADDR_W-1 -: SEC_AW];
  assign rf_sector = rf_block[BLK_AW-1 -: SEC_AW];
  // Only the select byte itself chooses user memory; no pin backs bit 3
  assign s_select  = (s_dsel[7:dpumm_pkg::DSEL_TYPE_LO] == dpumm_pkg::DEV_TYPE_CODE)
                   && (s_dsel[dpumm_pkg::DSEL_AREA_BIT] == dpumm_pkg::AREA_USER)
                   && (s_dsel[dpumm_pkg::DSEL_CS_HI] == s_cs_hi)
                   && (s_dsel[dpumm_pkg::DSEL_CS_LO] == s_cs_lo);

  // ----------------------------------------------------------------
  // Access checks
  // ----------------------------------------------------------------
  dpumm_chk_if rf_chk ();
  dpumm_chk_if ser_chk ();

  assign rf_chk.access_byte  = r_reg.sab[rf_sector];
  assign rf_chk.pwd_ok       = rf_pwd_ok;
  assign rf_chk.wr_lock      = 1'b0;
  assign rf_chk.serial_mode  = 1'b0;
  assign ser_chk.access_byte = r_reg.sab[s_sector];
  assign ser_chk.pwd_ok      = 1'b0;
  assign ser_chk.wr_lock     = ser_wr_lock[s_sector];
  assign ser_chk.serial_mode = 1'b1;

  dpumm_access_check u_rf_check (
    .chk (rf_chk.decider)
  );

  dpumm_access_check u_ser_check (
    .chk (ser_chk.decider)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.rf_ack  = 1'b0;
    r_next.ser_ack = 1'b0;
    // Serial clock, request fields and chip select pins pass two flops before any logic reads them
    r_next.scl_s1   = ser_scl;
    r_next.scl_s2   = r_reg.scl_s1;
    r_next.scl_prev = r_reg.scl_s2;
    r_next.in_s1    = {ser_req, ser_dev_sel, ser_addr, ser_wdata,
                       chip_select_bit_high, chip_select_bit_low};
    r_next.in_s2    = r_reg.in_s1;

    if (rf_req)
    begin
      r_next.rf_ack = 1'b1;
      if (rf_we)
      begin
        r_next.rf_denied = ~rf_chk.wr_ok;
        if (rf_chk.wr_ok)
        begin
          r_next.mem[rf_block] = rf_wdata;
        end
      end
      else
      begin
        r_next.rf_denied = ~rf_chk.rd_ok;
        // Denied reads return zeros so no protected data leaks out
        r_next.rf_rdata  = rf_chk.rd_ok ? r_reg.mem[rf_block] : 32'h0000_0000;
      end
    end

    // Serial access after the block port: a same-word clash lets the byte win
    if (scl_rise && s_req && s_select)
    begin
      r_next.ser_ack = 1'b1;
      if (!s_dsel[dpumm_pkg::DSEL_RW_BIT])
      begin
        r_next.ser_denied = ~ser_chk.wr_ok;
        if (ser_chk.wr_ok)
        begin
          r_next.mem[s_word][{s_lane, 3'h0} +: 8] = s_wdata;
        end
      end
      else
      begin
        r_next.ser_denied = 1'b0;
        r_next.ser_rdata  = r_reg.mem[s_word][{s_lane, 3'h0} +: 8];
      end
    end

    if (sab_wr)
    begin
      r_next.sab[sab_sector] = sab_data;
    end
    if (id_wr)
    begin
      if (id_sel_dsfid)
      begin
        r_next.dsfid = id_data;
      end
      else
      begin
        r_next.afi = id_data;
      end
    end
    if (pwd_wr)
    begin
      r_next.pwd[pwd_idx] = pwd_data;
    end
    // Passwords never leave the block, only the comparison does
    for (int i = 0; i < dpumm_pkg::PWD_BLOCKS; i++)
    begin
      r_next.pwd_match[i] = (r_reg.pwd[i] == pwd_cand);
    end

    if (!rst_n)
    begin
      r_next     = '0;
      // Array contents are nonvolatile and survive reset
      r_next.mem = r_reg.mem;
      for (int s = 0; s < SECTORS; s++)
      begin
        r_next.sab[s] = dpumm_pkg::SAB_RESET;
      end
      r_next.afi   = dpumm_pkg::ID_RESET;
      r_next.dsfid = dpumm_pkg::ID_RESET;
      for (int p = 0; p < dpumm_pkg::PWD_BLOCKS; p++)
      begin
        r_next.pwd[p] = dpumm_pkg::PWD_RESET;
      end
      r_next.uid = UID_VALUE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || ce)
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rf_ack             = r_reg.rf_ack;
  assign rf_denied          = r_reg.rf_denied;
  assign rf_rdata           = r_reg.rf_rdata;
  assign ser_ack            = r_reg.ser_ack;
  assign ser_denied         = r_reg.ser_denied;
  assign ser_rdata          = r_reg.ser_rdata;
  assign afi                = r_reg.afi;
  assign dsfid              = r_reg.dsfid;
  assign uid                = r_reg.uid;
  assign pwd_match          = r_reg.pwd_match;
  assign sector_access_byte = r_reg.sab;

endmodule

`default_nettype wire

// ---- dpumm_top_assertions.sv ----
// Checker for the user memory map top: block and byte verdicts,
// select gating, system area reset and update timing.
// Assumes binding to dpumm_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module dpumm_top_chk #(
  parameter int          SECTORS           = 64,
  parameter int          BLOCKS_PER_SECTOR = 32,
  parameter logic [63:0] UID_VALUE         = 64'h0,
  localparam int         BLK_AW            = $clog2(SECTORS * BLOCKS_PER_SECTOR),
  localparam int         SEC_AW            = $clog2(SECTORS),
  localparam int         ADDR_W            = BLK_AW + 2
) (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Enable and contactless port
  input wire logic                 ce,
  input wire logic                 rf_req,
  input wire logic                 rf_we,
  input wire logic [BLK_AW-1:0]    rf_block,
  input wire logic                 rf_pwd_ok,
  input wire logic                 rf_ack,
  input wire logic                 rf_denied,
  input wire logic [31:0]          rf_rdata,
  // Serial port
  input wire logic                 ser_ack,
  input wire logic                 ser_denied,
  input wire logic [7:0]           ser_dev_sel,
  input wire logic [ADDR_W-1:0]    ser_addr,
  input wire logic [SECTORS-1:0]   ser_wr_lock,
  // System area
  input wire logic                 id_wr,
  input wire logic                 id_sel_dsfid,
  input wire logic [7:0]           id_data,
  input wire logic [7:0]           afi,
  input wire logic [63:0]          uid,
  input wire logic [SECTORS-1:0][7:0] sector_access_byte
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic refused(input logic [7:0] b, input logic we, input logic pw);
    if (!b[0] || b[2:1] == 2'h1)
      return 1'b0;
    if (b[2:1] == 2'h0)
      return we & ~pw;
    return ~pw;
  endfunction

  // Verdict worked out from the byte in force when the request is taken
  logic exp_den_reg;
  always_ff @(posedge ref_clk)
    exp_den_reg <= refused(sector_access_byte[rf_block[BLK_AW-1:BLK_AW-SEC_AW]], rf_we, rf_pwd_ok);

  // A frozen cycle holds the ack, so only cycles that ran are judged
  property p_rf_ack; $past(ce) |-> rf_ack == $past(rf_req); endproperty
  property p_rf_verdict; rf_ack |-> rf_denied == exp_den_reg; endproperty
  property p_rf_zero; rf_ack && rf_denied && !$past(rf_we) |-> rf_rdata == 32'h0000_0000;
  endproperty
  property p_ser_sel; ser_ack |-> ser_dev_sel[7:4] == 4'ha && !ser_dev_sel[3]; endproperty
  property p_ser_lock;
    ser_ack && !ser_dev_sel[0] |-> ser_denied == ser_wr_lock[ser_addr[ADDR_W-1:ADDR_W-SEC_AW]];
  endproperty
  property p_ser_rd; ser_ack && ser_dev_sel[0] |-> !ser_denied; endproperty
  property p_sab_reset; $rose(rst_n) |-> sector_access_byte == '0; endproperty
  property p_uid; uid == UID_VALUE; endproperty
  property p_afi; ce && id_wr && !id_sel_dsfid |=> afi == $past(id_data); endproperty

  a_rf_ack: assert property (p_rf_ack) else $error("block ack timing wrong");
  a_rf_verdict: assert property (p_rf_verdict) else $error("block verdict wrong");
  a_rf_zero: assert property (p_rf_zero) else $error("refused read gave data");
  a_ser_sel: assert property (p_ser_sel) else $error("bad select accepted");
  a_ser_lock: assert property (p_ser_lock) else $error("byte lock verdict wrong");
  a_ser_rd: assert property (p_ser_rd) else $error("byte read refused");
  a_sab_reset: assert property (p_sab_reset) else $error("access bytes not cleared");
  a_uid: assert property (p_uid) else $error("identifier changed");
  a_afi: assert property (p_afi) else $error("family id not written");

  c_rf_den: cover property (rf_ack && rf_denied);
  c_ser_den: cover property (ser_ack && ser_denied);
  c_ser_rd: cover property (ser_ack && ser_dev_sel[0]);
endmodule

bind dpumm_top dpumm_top_chk #(.SECTORS(SECTORS), .BLOCKS_PER_SECTOR(BLOCKS_PER_SECTOR),
  .UID_VALUE(UID_VALUE)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .rf_req(rf_req),
  .rf_we(rf_we), .rf_block(rf_block), .rf_pwd_ok(rf_pwd_ok), .rf_ack(rf_ack),
  .rf_denied(rf_denied), .rf_rdata(rf_rdata), .ser_ack(ser_ack), .ser_denied(ser_denied),
  .ser_dev_sel(ser_dev_sel), .ser_addr(ser_addr), .ser_wr_lock(ser_wr_lock), .id_wr(id_wr),
  .id_sel_dsfid(id_sel_dsfid), .id_data(id_data), .afi(afi), .uid(uid),
  .sector_access_byte(sector_access_byte));

`default_nettype wire
